// >>> logic/adh_bank.sv
`timescale 1ns/1ps
`include "adh_map.svh"

module adh_bank
    import adh_pkg::*;
(
    // Clock and control.
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              ce,
    // Memory-space register access.
    input  wire adh_mem_req_t      req,
    output adh_mem_rsp_t           rsp_q,
    // Command issue and drive answers, one bit per port.
    input  wire logic [3:0]        cmd_issue,
    input  wire logic [3:0]        d2h_done,
    // Per-port state.
    output logic [3:0]             busy,
    output adh_decode_t [3:0]      port_dec,
    output adh_h2d_t [3:0]         h2d
);

    // Returns one when the address selects a device/head register.
    function automatic logic dh_hit(input logic [11:0] a);
        dh_hit = (a == `ADH_P0_DH_OFS) || (a == `ADH_P1_DH_OFS) ||
                 (a == `ADH_P2_DH_OFS) || (a == `ADH_P3_DH_OFS);
    endfunction

    // Returns the port index selected by a device/head address.
    function automatic logic [1:0] dh_port(input logic [11:0] a);
        dh_port = 2'(a[11:9] - 3'h1);
    endfunction

    // Returns the device/head offset of one port.
    function automatic logic [11:0] dh_ofs(input logic [1:0] p);
        case (p)
            2'h0: dh_ofs = `ADH_P0_DH_OFS;
            2'h1: dh_ofs = `ADH_P1_DH_OFS;
            2'h2: dh_ofs = `ADH_P2_DH_OFS;
            default: dh_ofs = `ADH_P3_DH_OFS;
        endcase
    endfunction

    logic [7:0] dh_all [`ADH_NPORTS];
    logic       rd_hit;
    logic       wr_hit;
    logic [1:0] sel;
    logic [7:0] dh_word;

    always_comb begin
        rd_hit  = req.rd && dh_hit(req.addr); // see R7
        wr_hit  = req.wr && dh_hit(req.addr); // see R7
        sel     = dh_port(req.addr);
        dh_word = dh_all[sel];
    end

    genvar gi;
    generate
        for (gi = 0; gi < `ADH_NPORTS; gi++) begin : g_port
            adh_port_reg u_port (
                .clk_sys   (clk_sys),
                .rst       (rst),
                .ce        (ce),
                .wr_en     (wr_hit && (sel == 2'(gi))),
                .wdata     (req.wdata),
                .cmd_issue (cmd_issue[gi]),
                .d2h_done  (d2h_done[gi]),
                .dh_q      (dh_all[gi]),
                .busy_q    (busy[gi]),
                .dec       (port_dec[gi]),
                .h2d_q     (h2d[gi])
            );
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rsp_q <= '0;
        end else if (ce) begin
            rsp_q.valid <= req.rd;
            rsp_q.hit   <= rd_hit;
            rsp_q.rdata <= rd_hit ? dh_word : 8'h00; // see R1 see R7
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    logic resv_any;
    always_comb begin
        resv_any = |((dh_all[0] | dh_all[1] | dh_all[2] | dh_all[3]) & `ADH_RESV_MASK);
    end

    chk_write_store: assert property ( // see R1
        ce && wr_hit |=> dh_all[$past(sel)] == ($past(req.wdata) & ~`ADH_RESV_MASK))
        else $error("Written device/head value not stored.");

    chk_read_data: assert property ( // see R1
        ce && rd_hit |=> rsp_q.valid && rsp_q.hit && rsp_q.rdata == $past(dh_word))
        else $error("Device/head read returned wrong data.");

    chk_mode_bit: assert property (port_dec[2].lba_mode == dh_all[2][6]) // see R3
        else $error("Addressing mode does not follow bit 6.");

    chk_head_chs: assert property ( // see R4
        !dh_all[1][6] |-> port_dec[1].head == dh_all[1][3:0] && port_dec[1].lba_27_24 == 4'h0)
        else $error("CHS head number wrong.");

    chk_lba_bits: assert property ( // see R5
        dh_all[3][6] |-> port_dec[3].lba_27_24 == dh_all[3][3:0] && port_dec[3].head == 4'h0)
        else $error("LBA bits 27 to 24 wrong.");

    chk_resv_zero: assert property (!resv_any) // see R8
        else $error("Reserved device/head bit held a one.");

    chk_decode_ofs: assert property (ce && req.rd && req.addr == `ADH_P2_DH_OFS |=> rsp_q.hit) // see R7
        else $error("Port 2 device/head offset not decoded.");

    chk_unmapped: assert property ( // see R7
        ce && req.rd && !dh_hit(req.addr) |=> rsp_q.valid && !rsp_q.hit && rsp_q.rdata == 8'h00)
        else $error("Unmapped read did not answer zero.");

    chk_busy_frame: assert property ( // see R9
        ce && cmd_issue[0] |=> busy[0] && h2d[0].valid && h2d[0].dh == $past(dh_all[0]))
        else $error("Command issue did not set busy and send frame.");

    chk_frame_pulse: assert property (ce && !cmd_issue[1] |=> !h2d[1].valid) // see R9
        else $error("Frame sent without command issue.");

    chk_rsp_freeze: assert property ( // see R1
        !ce |=> $stable(rsp_q))
        else $error("Read answer changed while the clock enable was low.");

    // Per-port checks on decoding, storage, command issue, clock enable and reset.
    genvar gc;
    generate
        for (gc = 0; gc < `ADH_NPORTS; gc++) begin : g_chk
            chk_port_mode: assert property ( // see R3
                port_dec[gc].lba_mode ==
                dh_all[gc][`ADH_MODE_BIT])
                else $error("Port addressing mode does not follow bit 6.");

            chk_port_head: assert property ( // see R4
                !dh_all[gc][`ADH_MODE_BIT] |->
                port_dec[gc].head == dh_all[gc][`ADH_LOW_MSB:`ADH_LOW_LSB] && port_dec[gc].lba_27_24 == 4'h0)
                else $error("Port CHS head number wrong.");

            chk_port_lba: assert property ( // see R5
                dh_all[gc][`ADH_MODE_BIT] |->
                port_dec[gc].lba_27_24 == dh_all[gc][`ADH_LOW_MSB:`ADH_LOW_LSB] && port_dec[gc].head == 4'h0)
                else $error("Port LBA bits 27 to 24 wrong.");

            chk_port_resv: assert property ( // see R8
                (dh_all[gc] & `ADH_RESV_MASK) ==
                8'h00)
                else $error("Port reserved bit held a one.");

            chk_port_hold: assert property ( // see R7
                !(ce && wr_hit && sel == 2'(gc)) |=>
                $stable(dh_all[gc]))
                else $error("Device/head register changed without its own write.");

            chk_port_write: assert property ( // see R1
                ce && req.wr && req.addr == dh_ofs(2'(gc)) |=>
                dh_all[gc] == ($past(req.wdata) & ~`ADH_RESV_MASK))
                else $error("Write at the port offset not stored.");

            chk_port_read: assert property ( // see R7
                ce && req.rd && req.addr == dh_ofs(2'(gc)) |=>
                rsp_q.hit && rsp_q.rdata == $past(dh_all[gc]))
                else $error("Read at the port offset returned wrong data.");

            chk_port_issue: assert property ( // see R9
                ce && cmd_issue[gc] |=>
                busy[gc] && h2d[gc].valid && h2d[gc].dh == $past(dh_all[gc]))
                else $error("Port command issue did not set busy and send frame.");

            chk_port_wins: assert property ( // see R9
                ce && cmd_issue[gc] && d2h_done[gc] |=>
                busy[gc])
                else $error("Drive answer beat a command issue in the same cycle.");

            chk_port_clear: assert property ( // see R9
                ce && d2h_done[gc] && !cmd_issue[gc] |=>
                !busy[gc])
                else $error("Drive answer did not clear busy.");

            chk_busy_hold: assert property ( // see R9
                !(cmd_issue[gc] || d2h_done[gc]) |=>
                $stable(busy[gc]))
                else $error("Busy changed without issue or answer.");

            chk_port_pulse: assert property ( // see R9
                ce && !cmd_issue[gc] |=>
                !h2d[gc].valid)
                else $error("Port frame sent without command issue.");

            chk_frame_hold: assert property ( // see R2
                !(ce && cmd_issue[gc]) |=>
                $stable(h2d[gc].dh))
                else $error("Frame parameter changed without command issue.");

            chk_port_freeze: assert property ( // see R9
                !ce |=>
                $stable(busy[gc]) && $stable(h2d[gc]))
                else $error("Port state changed while the clock enable was low.");

            chk_port_reset: assert property ( // see R1
                disable iff (1'b0) $past(rst) |->
                dh_all[gc] == `ADH_DH_RESET && !busy[gc] && h2d[gc] == '0)
                else $error("Port state not cleared by reset.");
        end
    endgenerate

    // Main scenarios; the bench reaches all but cov_cmd_after_write.
    cov_write_lba: cover property (ce && wr_hit && req.wdata[6]);
    cov_cmd_after_write: cover property (ce && wr_hit && sel == 2'h0 ##1 ce && cmd_issue[0]);
    cov_busy_clear: cover property (busy[3] ##1 ce && d2h_done[3] ##1 !busy[3]);
    cov_set_wins: cover property (ce && cmd_issue[3] && d2h_done[3]);
    cov_frozen_issue: cover property (!ce && cmd_issue[3]);

endmodule

// >>> logic/adh_map.svh
// Function
// R1: Each of four ports has an eight-bit read/write device/head parameter register.
// R2: Host writes device/head before the command register; command issue uses current value.
// R3: Bit 6 selects addressing mode: zero is CHS, one is LBA.
// R4: In CHS mode bits 3 down to 0 give the head number.
// R5: In 28-bit LBA mode bits 3 down to 0 give address bits 27 to 24.
// R6: In 48-bit LBA mode host sets bits 3 down to 0 all to one.
// R7: Register decodes at 218H, 418H, 618H and 818H for ports 0 to 3.
// R8: Bits 7, 5 and 4 are reserved and writes to them have no effect.
// R9: Command write sets busy and sends a host-to-device frame with the parameters.
`ifndef ADH_MAP_SVH
`define ADH_MAP_SVH

`define ADH_NPORTS      4
`define ADH_ADDR_W      12
`define ADH_P0_DH_OFS   12'h218
`define ADH_P1_DH_OFS   12'h418
`define ADH_P2_DH_OFS   12'h618
`define ADH_P3_DH_OFS   12'h818
`define ADH_DH_RESET    8'h00
`define ADH_RESV_MASK   8'hb0
`define ADH_MODE_BIT    6
`define ADH_LOW_MSB     3
`define ADH_LOW_LSB     0
`define ADH_LBA48_FILL  4'hf

`endif

// >>> logic/adh_pkg.sv
package adh_pkg;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } adh_mem_req_t;

    typedef struct packed {
        logic       valid;
        logic       hit;
        logic [7:0] rdata;
    } adh_mem_rsp_t;

    typedef struct packed {
        logic       lba_mode;
        logic [3:0] head;
        logic [3:0] lba_27_24;
    } adh_decode_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] dh;
    } adh_h2d_t;

endpackage

// >>> logic/adh_port_reg.sv
`timescale 1ns/1ps
`include "adh_map.svh"

module adh_port_reg
    import adh_pkg::*;
(
    // Clock and control.
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        ce,
    // Register write.
    input  wire logic        wr_en,
    input  wire logic [7:0]  wdata,
    // Command issue and drive answer.
    input  wire logic        cmd_issue,
    input  wire logic        d2h_done,
    // Port state.
    output logic [7:0]       dh_q,
    output logic             busy_q,
    output adh_decode_t      dec,
    output adh_h2d_t         h2d_q
);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dh_q <= `ADH_DH_RESET;
        end else if (ce && wr_en) begin
            dh_q <= wdata & ~`ADH_RESV_MASK; // see R1 see R8
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            busy_q <= 1'b0;
        end else if (ce) begin
            if (cmd_issue) begin
                busy_q <= 1'b1; // see R9
            end else if (d2h_done) begin
                busy_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            h2d_q <= '0;
        end else if (ce) begin
            h2d_q.valid <= cmd_issue; // see R9
            if (cmd_issue) begin
                h2d_q.dh <= dh_q; // see R2
            end
        end
    end

    always_comb begin
        dec.lba_mode  = dh_q[`ADH_MODE_BIT]; // see R3
        dec.head      = dh_q[`ADH_MODE_BIT] ? 4'h0 : dh_q[`ADH_LOW_MSB:`ADH_LOW_LSB]; // see R4
        dec.lba_27_24 = dh_q[`ADH_MODE_BIT] ? dh_q[`ADH_LOW_MSB:`ADH_LOW_LSB] : 4'h0; // see R5
    end

endmodule

// >>> verif/ata_device_head_register_tb.sv
`timescale 1ns/1ps
module ata_device_head_register_tb;
    import adh_pkg::*;
    logic              clk_sys;
    logic              rst;
    logic              ce;
    adh_mem_req_t      req;
    adh_mem_rsp_t      rsp_q;
    logic [3:0]        cmd_issue;
    logic [3:0]        d2h_done;
    logic [3:0]        busy;
    adh_decode_t [3:0] port_dec;
    adh_h2d_t [3:0]    h2d;
    int                bad_count;
    int                num_checks;
    int                cyc;
    logic [11:0]       ofs [4] = '{12'h218, 12'h418, 12'h618, 12'h818};

    adh_bank dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .req(req), .rsp_q(rsp_q), .cmd_issue(cmd_issue),
                  .d2h_done(d2h_done), .busy(busy), .port_dec(port_dec), .h2d(h2d));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Drives one write and lets the edge that takes it pass.
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk_sys);
        req.wr = 1'b0;
    endtask

    // Reads one address and compares valid, hit and data in the answer cycle.
    task automatic rd(input logic [11:0] a, input logic h, input logic [7:0] d);
        @(negedge clk_sys);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk_sys);
        req.rd = 1'b0;
        chk({rsp_q.valid, rsp_q.hit, rsp_q.rdata}, {1'b1, h, d});
    endtask

    task automatic t_rw();
        for (int p = 0; p < 4; p++) begin
            rd(ofs[p], 1'b1, 8'h00);
            chk(port_dec[p], 9'h000);
            wr(ofs[p], 8'hff);
            chk(port_dec[p], {1'b1, 4'h0, 4'hf});
            rd(ofs[p], 1'b1, 8'h4f);
            wr(ofs[p], 8'h0a + 8'(p));
            chk(port_dec[p], {1'b0, 4'ha + 4'(p), 4'h0});
        end
        rd(12'h21c, 1'b0, 8'h00);
        rd(12'h018, 1'b0, 8'h00);
        $display("test rw done");
    endtask

    task automatic t_cmd();
        wr(ofs[1], 8'h5a);
        cmd_issue = 4'h2;
        @(negedge clk_sys);
        cmd_issue = 4'h0;
        chk(busy, 4'h2);
        chk(h2d[1], {1'b1, 8'h4a});
        @(negedge clk_sys);
        chk({h2d[1].valid, busy}, 5'h02);
        d2h_done = 4'h2;
        @(negedge clk_sys);
        d2h_done = 4'h0;
        chk(busy, 4'h0);
        $display("test cmd done");
    endtask

    task automatic t_ce();
        ce = 1'b0;
        wr(ofs[2], 8'h40);
        ce = 1'b1;
        rd(ofs[2], 1'b1, 8'h0c);
        chk(port_dec[2], {1'b0, 4'hc, 4'h0});
        $display("test ce done");
    endtask

    // Port 3: write, read, issue and answer in one cycle, then a frozen cycle, a clear and a reset.
    task automatic t_edge();
        @(negedge clk_sys);
        req = '{wr: 1'b1, rd: 1'b1, addr: ofs[3], wdata: 8'h47};
        cmd_issue = 4'h8;
        d2h_done = 4'h8;
        for (int n = 0; n < 2; n++) begin
            @(negedge clk_sys);
            if (n == 0) begin
                ce = 1'b0;
                req = '{wr: 1'b0, rd: 1'b1, addr: ofs[0], wdata: 8'h00};
            end
            chk({rsp_q.hit, rsp_q.rdata}, {1'b1, 8'h0d});
            chk(h2d[3], {1'b1, 8'h0d});
            chk(busy, 4'h8);
            chk(port_dec[3], {1'b1, 4'h0, 4'h7});
        end
        ce = 1'b1;
        req = '0;
        cmd_issue = 4'h0;
        @(negedge clk_sys);
        d2h_done = 4'h0;
        chk({h2d[3].valid, rsp_q.valid, busy}, 6'h00);
        chk(h2d[3], 9'h00d);
        @(negedge clk_sys);
        rst = 1'b1;
        @(negedge clk_sys);
        rst = 1'b0;
        chk(h2d[3], 9'h000);
        chk(port_dec[3], 9'h000);
        rd(ofs[1], 1'b1, 8'h00);
        $display("test edge done");
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            end_sim();
        end
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        req = '0;
        cmd_issue = 4'h0;
        d2h_done = 4'h0;
        repeat (20) @(negedge clk_sys);
        rst = 1'b0;
        t_rw();
        t_cmd();
        t_ce();
        t_edge();
        end_sim();
    end
endmodule
